/* File: core/rmpc_pkg.sv */
package rmpc_pkg;

  // register bus shape
  localparam int RMPC_AW = 8;
  localparam int RMPC_DW = 32;

  // register offsets
  localparam logic [7:0] RMPC_OFS_SYSCTL = 8'h00;
  localparam logic [7:0] RMPC_OFS_PFDIR = 8'h04;
  localparam logic [7:0] RMPC_OFS_PFDATA = 8'h08;
  localparam logic [7:0] RMPC_OFS_PFIN = 8'h0C;
  localparam logic [7:0] RMPC_OFS_INTERRUPT_MASK_REG = 8'h10;
  localparam logic [7:0] RMPC_OFS_ICNTL = 8'h14;
  localparam logic [7:0] RMPC_OFS_MODE = 8'h18;
  localparam logic [7:0] RMPC_OFS_VECTOR = 8'h1C;
  localparam logic [7:0] RMPC_OFS_EVSTAT = 8'h20;
  localparam logic [7:0] RMPC_OFS_EVCLR = 8'h24;
  localparam logic [7:0] RMPC_OFS_EVEN = 8'h28;

  // system control fields
  localparam int RMPC_SYS_SPBFLAG = 0;
  localparam int RMPC_SYS_GOMODE = 1;
  localparam int RMPC_SYS_FLAGOUT = 2;
  localparam int RMPC_SYS_FLAGIN = 3;

  // strap positions on the flag pins
  localparam int RMPC_STRAP_C = 2;
  localparam int RMPC_NSTRAP = 4;

  // serial port b pin positions
  localparam int RMPC_SPB_DIN = 1;
  localparam int RMPC_SPB_DOUT = 2;
  localparam int RMPC_SPB_RFS = 3;
  localparam int RMPC_SPB_TFS = 4;

  // interrupt sources, highest priority first
  localparam int RMPC_NIRQ = 6;
  localparam int RMPC_IRQ_B = 0;
  localparam int RMPC_IRQ_L1 = 1;
  localparam int RMPC_IRQ_L0 = 2;
  localparam int RMPC_IRQ_E = 3;
  localparam int RMPC_IRQ_S1 = 4;
  localparam int RMPC_IRQ_S0 = 5;
  localparam logic [15:0] RMPC_VEC [RMPC_NIRQ] = '{16'h0004, 16'h0008, 16'h000C, 16'h0018, 16'h0020, 16'h0024};

  // events and reset values
  localparam int RMPC_NEV = 3;
  localparam logic [7:0] RMPC_PFDIR_RST = 8'h00;
  localparam logic [7:0] RMPC_PFDATA_RST = 8'hFF;
  localparam logic [5:0] RMPC_INTERRUPT_MASK_REG_RST = 6'h00;
  localparam logic [2:0] RMPC_ICNTL_RST = 3'h0;
  localparam logic [3:0] RMPC_SYS_RST = 4'h4;

  // core side memory request
  typedef struct packed {
    logic [13:0] addr;
    logic [23:0] data;
    logic dataOe;
    logic byteAcc;
    logic [7:0] byteAddr;
  } rmpc_mem_t;

  // captured operating mode
  typedef struct packed {
    logic hostMode;
    logic [3:0] straps;
  } rmpc_mode_t;

  typedef enum logic {BUS_OWN, BUS_GRANT} rmpc_bus_t;

endpackage

/* File: core/rmpc_irq_sense.sv */
`timescale 1ns/10ps
module rmpc_irq_sense #(
  parameter int N = 6
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [N-1:0] levelN,
  input wire logic [N-1:0] edgeMode,
  input wire logic [N-1:0] ackClr,
  output logic [N-1:0] req
);
  import rmpc_pkg::*;

  logic [N-1:0] prevN_reg;

  // per input level follow or falling edge latch
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_src
      wire fallSeen = prevN_reg[i] & ~levelN[i];
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          prevN_reg[i] <= 1'b1;
          req[i] <= 1'b0;
        end else begin
          prevN_reg[i] <= levelN[i];
          if (!edgeMode[i]) begin
            req[i] <= ~levelN[i];
          end else if (fallSeen) begin
            req[i] <= 1'b1; // set wins over ack
          end else if (ackClr[i]) begin
            req[i] <= 1'b0;
          end
        end
      end
    end
  endgenerate

endmodule // rmpc_irq_sense

/* File: core/rmpc_top.sv */
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
module rmpc_top (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [rmpc_pkg::RMPC_AW-1:0] busAddr,
  input wire logic [rmpc_pkg::RMPC_DW-1:0] busWdata,
  input wire logic busWe,
  input wire logic busRe,
  output logic [rmpc_pkg::RMPC_DW-1:0] busRdata,
  input wire logic [7:0] progFlagIn,
  output logic [7:0] progFlagOut,
  output logic [7:0] progFlagOe,
  input wire logic [4:0] spbPinIn,
  output logic [4:0] spbPinOut,
  output logic [4:0] spbPinOe,
  input wire logic [4:0] spCoreOut,
  input wire logic [4:0] spCoreOe,
  output logic [4:0] spCoreIn,
  input wire rmpc_pkg::rmpc_mem_t coreMem,
  input wire logic coreBusIdle,
  input wire logic coreExtReq,
  input wire logic coreIrqAck,
  output logic coreHalt,
  output logic [13:0] extAddrOut,
  output logic [13:0] extAddrOe,
  output logic [23:0] extDataOut,
  output logic [23:0] extDataOe,
  output logic byteMemDmaEn,
  output logic hostDmaEn,
  output logic fullMemMode,
  input wire logic busRequestN,
  output logic busGrantN,
  output logic busGrantHungN,
  output logic vecValid,
  output logic [15:0] vecAddr,
  output logic irqOut
);
  import rmpc_pkg::*;

  logic capturedReg;
  rmpc_mode_t mode_reg;
  logic [3:0] sysctl_reg;
  logic [7:0] pfDir_reg;
  logic [7:0] pfData_reg;
  logic [5:0] interrupt_mask_reg_reg;
  logic [2:0] icntl_reg;
  logic [2:0] evStat_reg;
  logic [2:0] evEn_reg;
  logic [2:0] vecIdx_reg;
  rmpc_bus_t busState_reg;
  rmpc_bus_t busState_next;
  logic [5:0] irqReq;
  logic [31:0] rdata_next;

  // register decode
  wire wrSys = busWe && busAddr == RMPC_OFS_SYSCTL;
  wire wrDir = busWe && busAddr == RMPC_OFS_PFDIR;
  wire wrData = busWe && busAddr == RMPC_OFS_PFDATA;
  wire wrMask = busWe && busAddr == RMPC_OFS_INTERRUPT_MASK_REG;
  wire wrCntl = busWe && busAddr == RMPC_OFS_ICNTL;
  wire wrClr = busWe && busAddr == RMPC_OFS_EVCLR;
  wire wrEn = busWe && busAddr == RMPC_OFS_EVEN;
  wire spbFlag = sysctl_reg[RMPC_SYS_SPBFLAG];
  wire goMode = sysctl_reg[RMPC_SYS_GOMODE];

  // pin level as seen by the interrupt logic, own drive included
  wire [7:0] pfLevel = (pfDir_reg & pfData_reg) | (~pfDir_reg & progFlagIn);

  // source order follows priority, serial sources only in flag role
  wire [5:0] irqLevelN = {spbFlag ? spbPinIn[RMPC_SPB_RFS] : 1'b1,
                          spbFlag ? spbPinIn[RMPC_SPB_TFS] : 1'b1,
                          pfLevel[4], pfLevel[5], pfLevel[6], pfLevel[7]};
  wire [5:0] edgeMode = {icntl_reg[1], icntl_reg[2], 1'b1, 1'b0, 1'b0, icntl_reg[0]};
  wire [5:0] ackOneHot = coreIrqAck ? 6'(6'h01 << vecIdx_reg) : 6'h00;
  wire [5:0] irqMasked = irqReq & interrupt_mask_reg_reg;

  // interrupt sources, flag pins 7:4 always feed both functions, serial port b pins 4:1 one role at a time except data in, which always feeds the flag in bit
  rmpc_irq_sense #(.N(RMPC_NIRQ)) u_sense (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .levelN(irqLevelN),
    .edgeMode(edgeMode),
    .ackClr(ackOneHot),
    .req(irqReq)
  );

  // highest priority unmasked source
  logic [2:0] pickIdx;
  logic pickAny;
  always_comb begin
    pickIdx = 3'h0;
    pickAny = 1'b0;
    for (int k = RMPC_NIRQ - 1; k >= 0; k--) begin
      if (irqMasked[k]) begin
        pickIdx = 3'(k);
        pickAny = 1'b1;
      end
    end
  end

  // vector output
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      vecValid <= 1'b0;
      vecAddr <= 16'h0000;
      vecIdx_reg <= 3'h0;
    end else begin
      vecValid <= pickAny;
      vecAddr <= pickAny ? RMPC_VEC[pickIdx] : 16'h0000;
      vecIdx_reg <= pickIdx;
    end
  end

  // strap capture on the first edge after reset release
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      capturedReg <= 1'b0;
      mode_reg <= '0;
    end else if (!capturedReg) begin
      capturedReg <= 1'b1;
      mode_reg.straps <= progFlagIn[RMPC_NSTRAP-1:0];
      mode_reg.hostMode <= progFlagIn[RMPC_STRAP_C];
    end
  end

  // mode decode, fixed until next reset
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      fullMemMode <= 1'b0;
      byteMemDmaEn <= 1'b0;
      hostDmaEn <= 1'b0;
    end else begin
      fullMemMode <= capturedReg && !mode_reg.hostMode;
      byteMemDmaEn <= capturedReg && !mode_reg.hostMode;
      hostDmaEn <= capturedReg && mode_reg.hostMode;
    end
  end

  // software registers
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sysctl_reg <= RMPC_SYS_RST;
      pfDir_reg <= RMPC_PFDIR_RST;
      pfData_reg <= RMPC_PFDATA_RST;
      interrupt_mask_reg_reg <= RMPC_INTERRUPT_MASK_REG_RST;
      icntl_reg <= RMPC_ICNTL_RST;
      evEn_reg <= '0;
    end else begin
      if (wrSys) sysctl_reg[2:0] <= busWdata[2:0];
      sysctl_reg[RMPC_SYS_FLAGIN] <= spbPinIn[RMPC_SPB_DIN];
      if (wrDir && capturedReg) pfDir_reg <= busWdata[7:0];
      if (wrData) pfData_reg <= busWdata[7:0];
      if (wrMask) interrupt_mask_reg_reg <= busWdata[5:0];
      if (wrCntl) icntl_reg <= busWdata[2:0];
      if (wrEn) evEn_reg <= busWdata[2:0];
    end
  end

  // flag pin drive
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      progFlagOut <= RMPC_PFDATA_RST;
      progFlagOe <= RMPC_PFDIR_RST;
    end else begin
      progFlagOut <= pfData_reg;
      progFlagOe <= pfDir_reg;
    end
  end

  // serial port b pin role, reconfigurable while running
  wire [4:0] roleMask = spbFlag ? 5'h1E : 5'h00;
  wire [4:0] flagOe = 5'(1) << RMPC_SPB_DOUT;
  wire [4:0] flagOut = 5'(sysctl_reg[RMPC_SYS_FLAGOUT]) << RMPC_SPB_DOUT;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      spbPinOut <= 5'h00;
      spbPinOe <= 5'h00;
      spCoreIn <= 5'h1F;
    end else begin
      spbPinOut <= (spCoreOut & ~roleMask) | (flagOut & roleMask);
      spbPinOe <= (spCoreOe & ~roleMask) | (flagOe & roleMask);
      spCoreIn <= spbPinIn | roleMask;
    end
  end

  // bus request and grant
  always_comb begin
    busState_next = busState_reg;
    case (busState_reg)
      BUS_OWN: if (!busRequestN && coreBusIdle && capturedReg) busState_next = BUS_GRANT;
      BUS_GRANT: if (busRequestN) busState_next = BUS_OWN;
      default: busState_next = BUS_OWN;
    endcase
  end

  wire grantNext = busState_next == BUS_GRANT;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      busState_reg <= BUS_OWN;
      busGrantN <= 1'b1;
      busGrantHungN <= 1'b1;
      coreHalt <= 1'b0;
    end else begin
      busState_reg <= busState_next;
      busGrantN <= !grantNext;
      busGrantHungN <= !(grantNext && goMode && coreExtReq);
      coreHalt <= grantNext && !goMode;
    end
  end

  // external bus drive, released while granted
  wire driveBus = capturedReg && busState_next == BUS_OWN;
  wire fullDrive = driveBus && !mode_reg.hostMode;
  wire hiByte = coreMem.byteAcc;
  wire [13:0] addrOeNext = fullDrive ? 14'h3FFF : (driveBus ? 14'h0001 : 14'h0000);
  wire [23:0] dataHi = {hiByte ? coreMem.byteAddr : coreMem.data[23:16], coreMem.data[15:0]};
  wire [15:0] hiOe = (driveBus && (coreMem.dataOe || (hiByte && fullDrive))) ? 16'hFFFF : 16'h0000;
  wire [7:0] loOe = (fullDrive && coreMem.dataOe) ? 8'hFF : 8'h00;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      extAddrOut <= 14'h0000;
      extAddrOe <= 14'h0000;
      extDataOut <= 24'h000000;
      extDataOe <= 24'h000000;
    end else begin
      extAddrOut <= coreMem.addr & addrOeNext;
      extAddrOe <= addrOeNext;
      extDataOut <= dataHi;
      extDataOe <= {hiOe, loOe};
    end
  end

  // event status, set wins over clear
  wire [2:0] evSet = {coreIrqAck, grantNext && goMode && coreExtReq,
                      grantNext && busState_reg == BUS_OWN};
  wire [2:0] evClr = wrClr ? busWdata[2:0] : 3'h0;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      evStat_reg <= '0;
      irqOut <= 1'b0;
    end else begin
      evStat_reg <= (evStat_reg & ~evClr) | evSet;
      irqOut <= |(((evStat_reg & ~evClr) | evSet) & evEn_reg);
    end
  end

  // read mux, data stand one cycle after the strobe
  always_comb begin
    rdata_next = 32'h00000000;
    case (busAddr)
      RMPC_OFS_SYSCTL: rdata_next = {28'h0000000, sysctl_reg};
      RMPC_OFS_PFDIR: rdata_next = {24'h000000, pfDir_reg};
      RMPC_OFS_PFDATA: rdata_next = {24'h000000, pfData_reg};
      RMPC_OFS_PFIN: rdata_next = {24'h000000, pfLevel};
      RMPC_OFS_INTERRUPT_MASK_REG: rdata_next = {26'h0000000, interrupt_mask_reg_reg};
      RMPC_OFS_ICNTL: rdata_next = {29'h00000000, icntl_reg};
      RMPC_OFS_MODE: rdata_next = {26'h0000000, capturedReg, mode_reg};
      RMPC_OFS_VECTOR: rdata_next = {7'h00, vecValid, 2'h0, irqReq, vecAddr};
      RMPC_OFS_EVSTAT: rdata_next = {29'h00000000, evStat_reg};
      RMPC_OFS_EVEN: rdata_next = {29'h00000000, evEn_reg};
      default: rdata_next = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      busRdata <= 32'h00000000;
    end else begin
      busRdata <= busRe ? rdata_next : 32'h00000000;
    end
  end

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  chk_strap_hold: assert property (capturedReg |=> $stable(mode_reg.straps))
    else $error("straps changed after capture");
  chk_mode_fixed: assert property (capturedReg |=> $stable(mode_reg.hostMode) && hostDmaEn == mode_reg.hostMode)
    else $error("memory mode changed while running");
  chk_pf_drive: assert property (capturedReg && wrDir |=> ##1 progFlagOe == $past(busWdata[7:0], 2))
    else $error("flag direction not applied");
  chk_vector_pick: assert property (irqMasked[RMPC_IRQ_L1] && !irqMasked[RMPC_IRQ_B]
                                    |=> vecValid && vecAddr == 16'h0008)
    else $error("wrong vector for level one");
  chk_level_follow: assert property (!pfLevel[5] |=> irqReq[RMPC_IRQ_L0])
    else $error("level interrupt not followed");
  chk_edge_latch: assert property ($fell(pfLevel[4]) |=> irqReq[RMPC_IRQ_E])
    else $error("edge interrupt not latched");
  chk_share_both: assert property (!pfDir_reg[6] && !progFlagIn[6] |=> irqReq[RMPC_IRQ_L1])
    else $error("shared pin lost interrupt function");
  chk_spb_flag: assert property (spbFlag |=> spbPinOe[RMPC_SPB_DOUT]
                                 && spbPinOut[RMPC_SPB_DOUT] == $past(sysctl_reg[RMPC_SYS_FLAGOUT]))
    else $error("flag output not on serial pin");
  chk_full_addr: assert property (fullDrive |=> extAddrOe == 14'h3FFF && extAddrOut == $past(coreMem.addr))
    else $error("address bus not driven");
  chk_byte_hi: assert property (fullDrive && coreMem.byteAcc
                                |=> extDataOut[23:16] == $past(coreMem.byteAddr) && extDataOe[23])
    else $error("byte address missing on upper data");
  chk_host_lim: assert property (capturedReg && mode_reg.hostMode |=> extAddrOe[13:1] == 13'h0000)
    else $error("host mode drove full address");
  chk_full_dma: assert property (capturedReg && !mode_reg.hostMode |=> byteMemDmaEn && !hostDmaEn)
    else $error("full memory mode not decoded");
  chk_grant_halt: assert property (!busGrantN && !goMode |-> coreHalt && extAddrOe == 14'h0000)
    else $error("grant without halt or bus release");
  chk_grant_drop: assert property (!busGrantN && busRequestN |=> busGrantN)
    else $error("grant held after request dropped");
  chk_grant_idle: assert property (busState_reg == BUS_OWN && !coreBusIdle |=> busGrantN)
    else $error("grant given while core busy");
  // interrupt sensitivity and serial role
  chk_edge_hold: assert property (icntl_reg[0] && irqReq[RMPC_IRQ_B] && !ackOneHot[RMPC_IRQ_B]
                                  |=> irqReq[RMPC_IRQ_B])
    else $error("edge configured request not held");
  chk_ack_clear: assert property (coreIrqAck && vecIdx_reg == 3'(RMPC_IRQ_E) && !$fell(pfLevel[4])
                                  |=> !irqReq[RMPC_IRQ_E])
    else $error("edge latch not cleared by ack");
  chk_serial_lvl: assert property (!spbFlag && !icntl_reg[1] |=> !irqReq[RMPC_IRQ_S0])
    else $error("serial interrupt active in serial role");

  cov_grant: cover property (!busRequestN ##[1:20] !busGrantN);
  cov_hung: cover property (!busGrantHungN);
  cov_vector: cover property (vecValid && vecAddr == 16'h0018);
  cov_host: cover property (hostDmaEn);
  cov_edge_b: cover property (icntl_reg[0] && vecAddr == 16'h0004);

endmodule // rmpc_top

/* File: tb/rmpc_ext_model.sv */
`timescale 1ns/10ps
// far side: flag pin wiring and an external bus master
module rmpc_ext_model (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] progFlagOut,
  input wire logic [7:0] progFlagOe,
  input wire logic [7:0] pinDrv,
  input wire logic wantBus,
  input wire logic busGrantN,
  output logic [7:0] progFlagIn,
  output logic busRequestN,
  output logic extOwns
);
  // pin level: the device wins where it drives, else the outside level
  assign progFlagIn = (progFlagOe & progFlagOut) | (~progFlagOe & pinDrv);
  // request raised after an edge and held until the master lets go
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) busRequestN <= 1'b1;
    else busRequestN <= ~wantBus;
  end
  // the master touches the buses only under grant
  assign extOwns = ~busRequestN & ~busGrantN;
endmodule // rmpc_ext_model

/* File: tb/testbench.sv */
`timescale 1ns/10ps
module testbench;
  import rmpc_pkg::*;
  logic clk_sys = 0, rstn = 0, busWe = 0, busRe = 0, coreBusIdle = 1, coreExtReq = 0, coreIrqAck = 0, wantBus = 0;
  logic [7:0] busAddr = 0, pinDrv = 8'hFF;
  logic [31:0] busWdata = 0, d;
  logic [4:0] spbPinIn = 5'h1F, spCoreOut = 0, spCoreOe = 0;
  rmpc_mem_t coreMem = '0;
  wire logic [31:0] busRdata;
  wire logic [7:0] progFlagIn, progFlagOut, progFlagOe;
  wire logic [4:0] spbPinOut, spbPinOe, spCoreIn;
  wire logic [13:0] extAddrOut, extAddrOe;
  wire logic [23:0] extDataOut, extDataOe;
  wire logic [15:0] vecAddr;
  wire logic coreHalt, byteMemDmaEn, hostDmaEn, fullMemMode, busRequestN, busGrantN, busGrantHungN;
  wire logic vecValid, irqOut, extOwns;
  int errors = 0, cmp_count = 0, cyc = 0, seed = 66764, i;
  logic [31:0] r;

  rmpc_top u_rmpc_top (.clk_sys(clk_sys), .rstn(rstn), .busAddr(busAddr), .busWdata(busWdata), .busWe(busWe),
    .busRe(busRe), .busRdata(busRdata), .progFlagIn(progFlagIn), .progFlagOut(progFlagOut), .progFlagOe(progFlagOe),
    .spbPinIn(spbPinIn), .spbPinOut(spbPinOut), .spbPinOe(spbPinOe), .spCoreOut(spCoreOut), .spCoreOe(spCoreOe),
    .spCoreIn(spCoreIn), .coreMem(coreMem), .coreBusIdle(coreBusIdle), .coreExtReq(coreExtReq),
    .coreIrqAck(coreIrqAck), .coreHalt(coreHalt), .extAddrOut(extAddrOut), .extAddrOe(extAddrOe),
    .extDataOut(extDataOut), .extDataOe(extDataOe), .byteMemDmaEn(byteMemDmaEn), .hostDmaEn(hostDmaEn),
    .fullMemMode(fullMemMode), .busRequestN(busRequestN), .busGrantN(busGrantN), .busGrantHungN(busGrantHungN),
    .vecValid(vecValid), .vecAddr(vecAddr), .irqOut(irqOut));
  rmpc_ext_model u_rmpc_ext_model (.clk_sys(clk_sys), .rstn(rstn), .progFlagOut(progFlagOut),
    .progFlagOe(progFlagOe), .pinDrv(pinDrv), .wantBus(wantBus), .busGrantN(busGrantN), .progFlagIn(progFlagIn),
    .busRequestN(busRequestN), .extOwns(extOwns));

  always #5 clk_sys = ~clk_sys;
  // hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    busWe <= 1;
    busAddr <= a;
    busWdata <= v;
    @(posedge clk_sys);
    busWe <= 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    busRe <= 1;
    busAddr <= a;
    @(posedge clk_sys);
    busRe <= 0;
    #1 d = busRdata;
  endtask
  // straps held across release and three cycles past it; the caller lets them go
  task automatic do_reset(input logic [3:0] s);
    rstn <= 0;
    pinDrv <= {4'hF, s};
    repeat (20) @(posedge clk_sys);
    rstn <= 1;
    settle(3);
  endtask
  task automatic grab();
    wantBus <= 1;
    for (i = 0; i < 20 && busGrantN !== 1'b0; i++) settle(1);
    settle(2);
  endtask
  // expected vector for the low pins 7:5, highest priority first
  function automatic logic [15:0] vec_of(input logic [2:0] low);
    if (low[2]) return RMPC_VEC[RMPC_IRQ_B];
    if (low[1]) return RMPC_VEC[RMPC_IRQ_L1];
    return RMPC_VEC[RMPC_IRQ_L0];
  endfunction

  initial begin
    do_reset(4'hB);
    pinDrv <= 8'hF4;
    settle(2);
    rd(RMPC_OFS_MODE);
    chk(d[5:0], 6'h2B);
    chk({fullMemMode, byteMemDmaEn, hostDmaEn}, 3'b110);
    rd(RMPC_OFS_PFDATA);
    chk(d, 32'hFF);
    rd(RMPC_OFS_PFDIR);
    chk(d, 32'h0);
    rd(8'h3C);
    chk(d, 32'h0);
    rd(RMPC_OFS_EVCLR);
    chk(d, 32'h0);
    // external buses in full mode
    for (int k = 0; k < 8; k++) begin
      coreMem <= 48'({$random(seed), $random(seed)});
      settle(3);
      chk(extAddrOut, coreMem.addr);
      chk(extAddrOe, 14'h3FFF);
      chk(extDataOe[23:8], (coreMem.dataOe | coreMem.byteAcc) ? 16'hFFFF : 16'h0);
      if (coreMem.byteAcc) chk(extDataOut[23:16], coreMem.byteAddr);
      chk(extDataOe[7:0], coreMem.dataOe ? 8'hFF : 8'h00);
      chk(extDataOut[15:0], coreMem.data[15:0]);
    end
    // strap pins as software flags
    r = $random(seed);
    wr(RMPC_OFS_PFDIR, 32'h0F);
    wr(RMPC_OFS_PFDATA, {24'h0, 4'hF, r[3:0]});
    settle(3);
    chk(progFlagOe, 8'h0F);
    chk(progFlagOut, {4'hF, r[3:0]});
    rd(RMPC_OFS_PFIN);
    chk(d[7:0], {4'hF, r[3:0]});
    wr(RMPC_OFS_PFDIR, 32'h0);
    wr(RMPC_OFS_INTERRUPT_MASK_REG, 32'h3F);
    wr(RMPC_OFS_ICNTL, 32'h0);
    // level pins at random, priority among them
    for (int k = 0; k < 10; k++) begin
      r = (k == 0) ? 32'h7 : $random(seed);
      pinDrv[7:5] <= ~r[2:0];
      settle(3);
      chk(vecValid, |r[2:0]);
      if (|r[2:0]) chk(vecAddr, vec_of(r[2:0]));
    end
    pinDrv[7:5] <= 3'h7;
    wr(RMPC_OFS_ICNTL, 32'h1);
    // short pulses on both edge pins stay latched until taken
    pinDrv[7:4] <= 4'h6;
    settle(1);
    pinDrv[7:4] <= 4'hF;
    settle(4);
    chk(vecAddr, RMPC_VEC[RMPC_IRQ_B]);
    for (int k = 0; k < 2; k++) begin
      coreIrqAck <= 1;
      settle(1);
      coreIrqAck <= 0;
      settle(3);
      if (k == 0) chk(vecAddr, RMPC_VEC[RMPC_IRQ_E]);
    end
    chk(vecValid, 1'b0);
    rd(RMPC_OFS_EVSTAT);
    chk(d[2], 1'b1);
    // software drives the shared pin as a flag
    wr(RMPC_OFS_PFDATA, 32'hEF);
    wr(RMPC_OFS_PFDIR, 32'h10);
    settle(4);
    chk(vecAddr, RMPC_VEC[RMPC_IRQ_E]);
    wr(RMPC_OFS_INTERRUPT_MASK_REG, 32'h0);
    settle(3);
    chk(vecValid, 1'b0);
    wr(RMPC_OFS_PFDIR, 32'h0);
    wr(RMPC_OFS_PFDATA, 32'hFF);
    // serial port b role
    spbPinIn <= 5'h1D;
    wr(RMPC_OFS_SYSCTL, 32'h1);
    settle(3);
    chk({spbPinOe[RMPC_SPB_DOUT], spbPinOut[RMPC_SPB_DOUT]}, 2'b10);
    chk(spCoreIn[4:1], 4'hF);
    rd(RMPC_OFS_SYSCTL);
    chk(d[3:0], 4'h1);
    // serial irq0 pin in flag role
    spbPinIn <= 5'h15;
    wr(RMPC_OFS_INTERRUPT_MASK_REG, 32'h20);
    settle(3);
    chk(vecAddr, RMPC_VEC[RMPC_IRQ_S0]);
    spbPinIn <= 5'h1D;
    wr(RMPC_OFS_INTERRUPT_MASK_REG, 32'h0);
    wr(RMPC_OFS_SYSCTL, 32'h5);
    settle(3);
    chk(spbPinOut[RMPC_SPB_DOUT], 1'b1);
    r = $random(seed);
    spCoreOut <= r[4:0];
    spCoreOe <= 5'h1F;
    wr(RMPC_OFS_SYSCTL, 32'h4);
    settle(3);
    chk({spbPinOut, spbPinOe, spCoreIn}, {r[4:0], 5'h1F, 5'h1D});
    // bus grant in normal mode halts the core
    wr(RMPC_OFS_EVEN, 32'h7);
    // no grant while the core holds the bus
    coreBusIdle <= 0;
    wantBus <= 1;
    settle(4);
    chk(busGrantN, 1'b1);
    coreBusIdle <= 1;
    grab();
    chk({busGrantN, coreHalt, extOwns, irqOut}, 4'b0111);
    chk(extAddrOe, 14'h0);
    rd(RMPC_OFS_EVSTAT);
    chk(d[0], 1'b1);
    wantBus <= 0;
    settle(3);
    wr(RMPC_OFS_EVCLR, 32'h7);
    settle(2);
    chk({busGrantN, irqOut}, 2'b10);
    // go mode keeps running; hung when the core wants the bus
    wr(RMPC_OFS_SYSCTL, 32'h6);
    coreExtReq <= 1;
    grab();
    chk({busGrantN, busGrantHungN, coreHalt}, 3'b000);
    wantBus <= 0;
    coreExtReq <= 0;
    settle(3);
    chk(busGrantHungN, 1'b1);
    // second reset in host mode
    do_reset(4'h4);
    pinDrv <= 8'hFF;
    coreMem <= 48'({$random(seed), $random(seed)});
    settle(3);
    rd(RMPC_OFS_MODE);
    chk(d[5:0], 6'h34);
    chk({fullMemMode, byteMemDmaEn, hostDmaEn}, 3'b001);
    chk(extAddrOe, 14'h0001);
    chk(extDataOe, coreMem.dataOe ? 24'hFFFF00 : 24'h000000);
    give_verdict();
  end
endmodule // testbench
